/* File: hdl/sal_pkg.sv */
/*
 Package for the socket audio and activity LED block: register map,
 field positions, reset values, timing constants and pin-routing codes.
 Assumes a 50 MHz clock and a 32-bit classic Wishbone register bus.
*/
`default_nettype none
package sal_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] SAL_ADR_CARD_CTRL = 4'h0;
   localparam logic [3:0] SAL_ADR_MF_ROUTE  = 4'h4;
   localparam logic [3:0] SAL_ADR_STATUS    = 4'h8;
   // Card control fields
   localparam int SAL_BIT_AUD_EN    = 1;
   localparam int SAL_BIT_PWM_ROUTE = 2;
   localparam logic [7:0] SAL_CTRL_RST = 8'h00;
   // Routing register: two 2-bit fields, one per multifunction pin
   localparam int SAL_MF_PINS     = 2;
   localparam int SAL_MF_FW       = 2;
   localparam logic [3:0] SAL_MF_RST = 4'h0;
   localparam logic [1:0] SAL_MF_OFF = 2'h0;
   localparam logic [1:0] SAL_MF_PWM = 2'h1;
   localparam logic [1:0] SAL_MF_LED = 2'h2;
   // Status fields
   localparam int SAL_ST_LED   = 0;
   localparam int SAL_ST_VALID = 1;
   localparam int SAL_ST_AUD   = 2;
   localparam logic [31:0] SAL_ZERO32 = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam longint SAL_CLK_HZ    = 64'd50_000_000;
   localparam longint SAL_LED_MS    = 64'd64;
   localparam longint SAL_LED_CYC   = SAL_CLK_HZ * SAL_LED_MS / 64'd1000;
   localparam int     SAL_CNT_W     = 24;
endpackage
`default_nettype wire

/* File: hdl/sal_stretch.sv */
/*
 Retriggerable pulse stretcher: output high for a fixed number of cycles
 after the last trigger. Assumes synchronous trigger and active-low reset.
*/
`default_nettype none
module sal_stretch
   import sal_pkg::*;
#(
   parameter int          CW    = SAL_CNT_W,
   parameter logic [CW-1:0] TERM = CW'(SAL_LED_CYC)
)(
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          ce,
   input  wire logic          trig,
   input  wire logic          kill,
   output var  logic          active
);
   logic [CW-1:0] cnt_q;

   // ---------------------------------------------------------------
   // Counter: reload on trigger, count down to idle
   // ---------------------------------------------------------------
   // Kill wins over trigger so the LED never sticks while clocks stop
   always_ff @(posedge clk)
   begin
      if (!resetn)
         cnt_q <= '0;
      else if (ce)
      begin
         if (kill)
            cnt_q <= '0;
         else if (trig)
            cnt_q <= TERM;
         else if (cnt_q != '0)
            cnt_q <= cnt_q - CW'(1);
      end
   end

   assign active = (cnt_q != '0);

   chk_kill_clears: assert property (@(posedge clk) disable iff (!resetn)
      (ce && kill) |=> !active) else $error("stretch not killed");
   chk_trig_loads: assert property (@(posedge clk) disable iff (!resetn)
      (ce && trig && !kill) |=> (cnt_q == TERM))
      else $error("stretch not reloaded");
endmodule
`default_nettype wire

/* File: hdl/sal_wb_regs.sv */
/*
 Classic Wishbone register slave for the block: card control, pin routing
 and a read-only status word. One wait state; unmapped reads give zero.
*/
`default_nettype none
module sal_wb_regs
   import sal_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [3:0]  wbAdr,
   input  wire logic [31:0] wbDatI,
   input  wire logic [3:0]  wbSel,
   input  wire logic        wbWe,
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic [2:0]  status,
   output logic [31:0]      wbDatO,
   output logic             wbAck,
   output logic [7:0]       cardCtrl,
   output logic [3:0]       mfRoute
);
   logic req;
   assign req = wbCyc && wbStb && !wbAck;

   // ---------------------------------------------------------------
   // Ack and read data
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wbAck  <= 1'b0;
         wbDatO <= SAL_ZERO32;
      end
      else if (ce)
      begin
         wbAck <= req;
         unique case (wbAdr)
            SAL_ADR_CARD_CTRL: wbDatO <= {24'h00_0000, cardCtrl};
            SAL_ADR_MF_ROUTE:  wbDatO <= {28'h000_0000, mfRoute};
            SAL_ADR_STATUS:    wbDatO <= {29'h0000_0000, status};
            default:           wbDatO <= SAL_ZERO32;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Writes take effect with the ack edge's request
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cardCtrl <= SAL_CTRL_RST;
         mfRoute  <= SAL_MF_RST;
      end
      else if (ce && req && wbWe && wbSel[0])
      begin
         if (wbAdr == SAL_ADR_CARD_CTRL)
            cardCtrl <= wbDatI[7:0];
         if (wbAdr == SAL_ADR_MF_ROUTE)
            mfRoute <= wbDatI[3:0];
      end
   end

   // A frozen slave holds its ack, so only a running cycle must drop it
   chk_ack_onecycle: assert property (@(posedge clk) disable iff (!resetn)
      (ce && wbAck) |=> !wbAck) else $error("ack held two cycles");
endmodule
`default_nettype wire

/* File: hdl/sal_socket_top.sv */
/*
 Socket audio routing and activity LED logic.
 Assumes all card and system inputs are synchronous to clk (PCI clock)
 and that software sets the audio and routing bits over Wishbone.
*/
// Summary of operation
// - In 16-bit I/O mode the second battery-detect line carries card audio.
// - Binary audio reaches the system audio pin only when its enable is set.
// - Route select sends CardBus PWM audio to the separate PWM output.
// - PWM audio output can be placed on a multifunction pin.
// - Activity LED can be placed on a multifunction pin.
// - A multifunction pin used as LED goes high on activity.
// - Dedicated socket LED output shows 16-bit and CardBus socket activity.
// - Each activity holds the LED high for 64 ms by a counter.
// - LED outputs are driven low whenever not high.
// - Activity counts only while card inserted, powered and out of reset.
// - 16-bit card: ready/interrupt line low counts as activity.
// - CardBus: frame, initiator ready or request active counts as activity.
// - Suspend, clock stop request, or D1/D2 force the LED off.
// - New activity restarts the 64 ms count and keeps the LED high.
`default_nettype none
module sal_socket_top
   import sal_pkg::*;
#(
   parameter int              CNT_W   = SAL_CNT_W,
   parameter logic [CNT_W-1:0] LED_CYC = CNT_W'(SAL_LED_CYC)
)(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   // Wishbone slave
   input  wire logic [3:0]  wbAdr,
   input  wire logic [31:0] wbDatI,
   input  wire logic [3:0]  wbSel,
   input  wire logic        wbWe,
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   output logic [31:0]      wbDatO,
   output logic             wbAck,
   // Card side
   input  wire logic        cardPresent,
   input  wire logic        cardPowered,
   input  wire logic        cardInReset,
   input  wire logic        cardIsCardbus,
   input  wire logic        cardIoMode,
   input  wire logic        bvd2Audio,
   input  wire logic        readyIrqN,
   input  wire logic        cframeN,
   input  wire logic        cirdyN,
   input  wire logic        creqN,
   // System side
   input  wire logic        suspendN,
   input  wire logic        clkStopReq,
   input  wire logic        pwrD1,
   input  wire logic        pwrD2,
   output logic             systemAudioOut,
   output logic             pwmAudioOut,
   output logic [1:0]       multifunctionPin,
   output logic             socketLedOut
);
   logic [7:0] cardCtrl;
   logic [3:0] mfRoute;
   logic       audioIn;
   logic       audEnable;
   logic       pwmSelect;
   logic       cardValid;
   logic       activity;
   logic       ledKill;
   logic       ledActive;
   logic       audioOn;
   logic [2:0] status;

   // ---------------------------------------------------------------
   // Register slave
   // ---------------------------------------------------------------
   sal_wb_regs u_regs (
      .clk      (clk),
      .resetn   (resetn),
      .ce       (ce),
      .wbAdr    (wbAdr),
      .wbDatI   (wbDatI),
      .wbSel    (wbSel),
      .wbWe     (wbWe),
      .wbCyc    (wbCyc),
      .wbStb    (wbStb),
      .status   (status),
      .wbDatO   (wbDatO),
      .wbAck    (wbAck),
      .cardCtrl (cardCtrl),
      .mfRoute  (mfRoute)
   );

   assign audEnable = cardCtrl[SAL_BIT_AUD_EN];
   assign pwmSelect = cardCtrl[SAL_BIT_PWM_ROUTE];

   // ---------------------------------------------------------------
   // Audio input selection
   // ---------------------------------------------------------------
   // A memory-mode 16-bit card uses this line as battery detect, not audio
   assign audioIn = cardValid && (cardIsCardbus || cardIoMode) && bvd2Audio;

   // Card present, powered and out of reset gates card audio and new activity; a running LED count continues
   assign cardValid = cardPresent && cardPowered && !cardInReset;

   // ---------------------------------------------------------------
   // Activity detection
   // ---------------------------------------------------------------
   always_comb
   begin
      activity = 1'b0;
      if (cardValid)
      begin
         if (cardIsCardbus)
            activity = !cframeN || !cirdyN || !creqN;
         else
            activity = !readyIrqN;
      end
   end

   // LED must drop before the clock stops, or it would appear stuck
   assign ledKill = !suspendN || clkStopReq || pwrD1 || pwrD2;

   sal_stretch #(
      .CW   (CNT_W),
      .TERM (LED_CYC)
   ) u_stretch (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .trig   (activity),
      .kill   (ledKill),
      .active (ledActive)
   );

   // PWM route takes CardBus audio away from the system pin
   assign audioOn = audEnable && !(pwmSelect && cardIsCardbus);

   assign status = {audioIn, cardValid, ledActive};

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         systemAudioOut <= 1'b0;
         pwmAudioOut    <= 1'b0;
         socketLedOut   <= 1'b0;
      end
      else if (ce)
      begin
         systemAudioOut <= audioOn && audioIn;
         pwmAudioOut    <= pwmSelect && cardIsCardbus && audioIn;
         socketLedOut   <= ledActive;
      end
   end

   // ---------------------------------------------------------------
   // Multifunction pins, one routing field each
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < SAL_MF_PINS; i++)
      begin : g_mf
         always_ff @(posedge clk)
         begin
            if (!resetn)
               multifunctionPin[i] <= 1'b0;
            else if (ce)
            begin
               unique case (mfRoute[i*SAL_MF_FW +: SAL_MF_FW])
                  SAL_MF_PWM: multifunctionPin[i] <= pwmSelect && cardIsCardbus
                                                     && audioIn;
                  SAL_MF_LED: multifunctionPin[i] <= ledActive;
                  default:    multifunctionPin[i] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_audio_gate: assert property (@(posedge clk) disable iff (!resetn)
      (ce && !audEnable) |=> !systemAudioOut) else $error("audio leaked");
   chk_io_mode: assert property (@(posedge clk) disable iff (!resetn)
      (ce && cardValid && !cardIsCardbus && cardIoMode && bvd2Audio && audEnable)
      |=> systemAudioOut) else $error("io audio lost");
   chk_pwm_route: assert property (@(posedge clk) disable iff (!resetn)
      (ce && pwmSelect && cardIsCardbus && audioIn) |=> pwmAudioOut)
      else $error("pwm not routed");
   chk_led_follow: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> (socketLedOut == $past(ledActive))) else $error("led mismatch");
   chk_act_lights: assert property (@(posedge clk) disable iff (!resetn)
      (ce && activity && !ledKill) ##1 ce |=> socketLedOut)
      else $error("activity not shown");
   chk_kill_dark: assert property (@(posedge clk) disable iff (!resetn)
      (ce && ledKill) ##1 ce |=> !socketLedOut) else $error("led not cut");
   chk_invalid_quiet: assert property (@(posedge clk) disable iff (!resetn)
      (ce && !cardValid && !ledActive) |=> !ledActive)
      else $error("activity from idle card");
   chk_ce_hold: assert property (@(posedge clk) disable iff (!resetn)
      !ce |=> ($stable(socketLedOut) && $stable(multifunctionPin)))
      else $error("outputs moved with enable low");
   chk_mf_led: assert property (@(posedge clk) disable iff (!resetn)
      (ce && mfRoute[1:0] == SAL_MF_LED) |=> (multifunctionPin[0] == $past(ledActive)))
      else $error("mf led wrong");
endmodule
`default_nettype wire

/* File: verification/sal_card_model.sv */
/*
 Card-side model: audio line and active-low activity lines of a
 16-bit card or a CardBus card. Assumes the bench picks the card kind.
*/
`default_nettype none
module sal_card_model
(
   input  wire logic       isCb,
   input  wire logic       audIn,
   input  wire logic [1:0] actSel,
   input  wire logic       actGo,
   output logic            bvd2Audio,
   output logic            readyIrqN,
   output logic            cframeN,
   output logic            cirdyN,
   output logic            creqN
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Card lines
   // ----------------------------------------
   // Audio passes as given, binary or PWM toggling
   assign bvd2Audio = audIn;
   // Activity lines idle high, one pulled low per request
   assign readyIrqN = !(actGo && !isCb);
   assign cframeN   = !(actGo && isCb && actSel == 2'h0);
   assign cirdyN    = !(actGo && isCb && actSel == 2'h1);
   assign creqN     = !(actGo && isCb && actSel == 2'h2);
endmodule
`default_nettype wire

/* File: verification/sal_socket_top_tb.sv */
/*
 Bench for sal_socket_top: registers, audio routing, LED stretch.
 Assumes a short LED count for run time; ce drops once to test freezing.
*/
`default_nettype none
module sal_socket_top_tb
   import sal_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic cb, io; logic [7:0] ctl; logic [3:0] mf; logic a, sys, pwm; logic [1:0] mfp;
   } sal_row_t;
   localparam int LC = 16; // Short stretch, keeps the run brief
   logic        clk = 1'h0, resetn = 1'h0, ce = 1'h1, wbWe = 1'h0, wbCyc = 1'h0;
   logic        wbStb = 1'h0, wbAck, systemAudioOut, pwmAudioOut, socketLedOut;
   logic        bvd2Audio, readyIrqN, cframeN, cirdyN, creqN, aud = 1'h0, actGo = 1'h0;
   logic        cardPresent = 1'h1, cardPowered = 1'h1, cardInReset = 1'h0;
   logic        cardIsCardbus = 1'h0, cardIoMode = 1'h1, suspendN = 1'h1;
   logic        clkStopReq = 1'h0, pwrD1 = 1'h0, pwrD2 = 1'h0;
   logic [1:0]  actSel = 2'h0, multifunctionPin;
   logic [3:0]  wbAdr = 4'h0, wbSel = 4'h0;
   logic [9:0]  pat = 10'h2D3;
   logic [31:0] wbDatI = 32'h0000_0000, wbDatO, q;
   int          err_total = 0, cmp_count = 0, n;
   sal_row_t    rows [9] = '{
      '{1'h0, 1'h1, 8'h00, 4'h9, 1'h1, 1'h0, 1'h0, 2'h0},
      '{1'h0, 1'h1, 8'h02, 4'h9, 1'h1, 1'h1, 1'h0, 2'h0},
      '{1'h0, 1'h0, 8'h02, 4'h9, 1'h1, 1'h0, 1'h0, 2'h0},
      '{1'h1, 1'h0, 8'h02, 4'h9, 1'h1, 1'h1, 1'h0, 2'h0},
      '{1'h1, 1'h0, 8'h02, 4'h9, 1'h0, 1'h0, 1'h0, 2'h0},
      '{1'h1, 1'h0, 8'h06, 4'h9, 1'h1, 1'h0, 1'h1, 2'h1},
      '{1'h0, 1'h1, 8'h06, 4'h5, 1'h1, 1'h1, 1'h0, 2'h0},
      '{1'h1, 1'h0, 8'h06, 4'hF, 1'h1, 1'h0, 1'h1, 2'h0},
      '{1'h1, 1'h0, 8'h06, 4'h0, 1'h1, 1'h0, 1'h1, 2'h0}};
   // ----------------------------------------
   // Clock, instances
   // ----------------------------------------
   initial
   begin
      forever #10 clk = ~clk;
   end
   sal_card_model card_u (.isCb(cardIsCardbus), .audIn(aud), .actSel, .actGo, .bvd2Audio,
      .readyIrqN, .cframeN, .cirdyN, .creqN);
   sal_socket_top #(.LED_CYC(24'(LC))) dut_u (.clk, .resetn, .ce, .wbAdr, .wbDatI, .wbSel,
      .wbWe, .wbCyc, .wbStb, .wbDatO, .wbAck, .cardPresent, .cardPowered, .cardInReset,
      .cardIsCardbus, .cardIoMode, .bvd2Audio, .readyIrqN, .cframeN, .cirdyN, .creqN,
      .suspendN, .clkStopReq, .pwrD1, .pwrD2, .systemAudioOut, .pwmAudioOut,
      .multifunctionPin, .socketLedOut);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // A wait that runs out ends the run at once
   task automatic hang();
      err_total++;
      report_and_stop();
   endtask
   // Classic cycle: held until ack is sampled, then one idle cycle
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int i;
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= d;
      wbSel <= 4'hF;
      i = 0;
      do @(posedge clk); while (wbAck !== 1'h1 && ++i < 20);
      if (i == 20) hang();
      q = wbDatO;
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      wbWe <= 1'h0;
      @(posedge clk);
   endtask
   // One-cycle activity on line k: 0 ready line, 1..3 CardBus lines
   task automatic pulse(input int k);
      cardIsCardbus <= (k != 0);
      actSel <= 2'(k - 1);
      actGo <= 1'h1;
      @(posedge clk);
      actGo <= 1'h0;
   endtask
   // Cycles that the LED stays high after it rises
   task automatic led_len(output int c);
      int i;
      c = 0;
      for (i = 0; i < 10 && socketLedOut !== 1'h1; i++) @(posedge clk);
      if (i == 10) hang();
      while (socketLedOut === 1'h1 && c < 200)
      begin
         @(posedge clk);
         c++;
      end
   endtask
   task automatic set_kill(input int k, input logic v);
      case (k)
         0: suspendN <= !v;
         1: clkStopReq <= v;
         2: pwrD1 <= v;
         default: pwrD2 <= v;
      endcase
   endtask
   task automatic set_bad(input int k, input logic v);
      case (k)
         0: cardPresent <= !v;
         1: cardPowered <= !v;
         default: cardInReset <= v;
      endcase
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      check(32'({systemAudioOut, pwmAudioOut, multifunctionPin}), 0);
      check(32'(socketLedOut), 0);
      wb(1'h0, SAL_ADR_CARD_CTRL, 0);
      check(q, 0);
      wb(1'h0, SAL_ADR_MF_ROUTE, 0);
      check(q, 0);
      wb(1'h1, 4'hC, 32'hFFFF_FFFF);
      wb(1'h0, 4'hC, 0);
      check(q, 0);
      wb(1'h0, SAL_ADR_STATUS, 0);
      check(32'(q[SAL_ST_VALID]), 1);
      $display("test reset and registers done");
      foreach (rows[i])
      begin
         wb(1'h1, SAL_ADR_CARD_CTRL, 32'(rows[i].ctl));
         wb(1'h1, SAL_ADR_MF_ROUTE, 32'(rows[i].mf));
         wb(1'h0, SAL_ADR_CARD_CTRL, 0);
         check(q, 32'(rows[i].ctl));
         cardIsCardbus <= rows[i].cb;
         cardIoMode <= rows[i].io;
         aud <= rows[i].a;
         repeat (4) @(posedge clk);
         check(32'(systemAudioOut), 32'(rows[i].sys));
         check(32'(pwmAudioOut), 32'(rows[i].pwm));
         check(32'(multifunctionPin), 32'(rows[i].mfp));
      end
      // Toggling audio: PWM form passes cycle for cycle
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk);
         aud <= pat[i];
         if (i >= 2) check(32'(pwmAudioOut), 32'(pat[i-2]));
      end
      $display("test audio routing done");
      // Both pins carry the LED so each routing field is exercised
      wb(1'h1, SAL_ADR_MF_ROUTE, 32'h0000_000A);
      for (int k = 0; k < 4; k++)
      begin
         pulse(k);
         led_len(n);
         check(n, LC);
      end
      // Pulses closer than the stretch keep the LED on
      repeat (5)
      begin
         pulse(1);
         repeat (LC - 4) @(posedge clk);
         check(32'(socketLedOut), 1);
      end
      check(32'(multifunctionPin), 32'h0000_0003);
      repeat (LC + 4) @(posedge clk);
      check(32'(socketLedOut), 0);
      check(32'(multifunctionPin), 0);
      // Clock enable low must freeze the stretch mid-count
      aud <= 1'h1;
      pulse(1);
      wb(1'h0, SAL_ADR_STATUS, 0);
      check(q, 32'h0000_0007);
      ce <= 1'h0;
      repeat (LC + 4) @(posedge clk);
      check(32'(socketLedOut), 1);
      ce <= 1'h1;
      repeat (LC + 4) @(posedge clk);
      check(32'(socketLedOut), 0);
      $display("test led stretch done");
      for (int k = 0; k < 3; k++)
      begin
         set_bad(k, 1'h1);
         pulse(2);
         repeat (4) @(posedge clk);
         check(32'(socketLedOut), 0);
         wb(1'h0, SAL_ADR_STATUS, 0);
         check(32'(q[SAL_ST_VALID]), 0);
         set_bad(k, 1'h0);
      end
      for (int k = 0; k < 4; k++)
      begin
         pulse(3);
         repeat (4) @(posedge clk);
         set_kill(k, 1'h1);
         repeat (3) @(posedge clk);
         check(32'(socketLedOut), 0);
         set_kill(k, 1'h0);
         repeat (3) @(posedge clk);
         check(32'(socketLedOut), 0);
      end
      $display("test validity and cut-off done");
      pulse(1);
      repeat (4) @(posedge clk);
      resetn <= 1'h0;
      repeat (2) @(posedge clk);
      check(32'(socketLedOut), 0);
      resetn <= 1'h1;
      repeat (3) @(posedge clk);
      check(32'(socketLedOut), 0);
      wb(1'h0, SAL_ADR_CARD_CTRL, 0);
      check(q, 0);
      wb(1'h0, SAL_ADR_MF_ROUTE, 0);
      check(q, 0);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
